// >>> bench/pcv_core_sva.sv
// Purpose: Port-level checker for pcv_core
// Assumes: One clock, async active-low reset
// Notes: Index registers are internal, so ROM address is checked by the bench
`timescale 1ns/10ps
module pcv_core_sva #(
  parameter PC_W = 10
) (
  input wire ref_clk,
  input wire rstn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire op_irq,
  input wire op_return_from_interrupt,
  input wire op_table_read,
  input wire op_add_pcl,
  input wire op_sub_pcl,
  input wire [PC_W-1:0] fetch_addr,
  input wire rom_rd,
  input wire busy,
  input wire user_area_exceeded,
  input wire [2:0] stack_depth
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_tbl_go;
    op_table_read && !busy && !op_irq && !op_return_from_interrupt;
  endsequence
  sequence s_tbl_done;
    rom_rd && busy ##1 !rom_rd && !busy;
  endsequence
  property p_tbl; s_tbl_go |=> s_tbl_done; endproperty
  property p_rst; $rose(rstn) |-> fetch_addr == 10'h000; endproperty
  property p_vec; op_irq && !busy |=> fetch_addr == 10'h008; endproperty
  property p_push;
    op_irq && !busy && stack_depth < 3'h4 |=> stack_depth == $past(stack_depth) + 3'h1;
  endproperty
  property p_full; op_irq && !busy && stack_depth == 3'h4 |=> stack_depth == 3'h4; endproperty
  property p_pop;
    op_return_from_interrupt && !op_irq && !busy && stack_depth != 3'h0
      |=> stack_depth == $past(stack_depth) - 3'h1;
  endproperty
  property p_sub;
    op_sub_pcl && !busy && !op_irq && !op_return_from_interrupt && !op_add_pcl
      |=> $stable(fetch_addr[PC_W-1:8]);
  endproperty
  property p_user; 1'b1 |=> user_area_exceeded == ($past(fetch_addr) > 10'h3fc); endproperty
  // Fixed single wait state, master holds the request
  property p_bus; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_tbl: assert property (p_tbl) else $error("table read timing wrong");
  a_rst: assert property (p_rst) else $error("fetch not at zero after reset");
  a_vec: assert property (p_vec) else $error("interrupt entry wrong");
  a_push: assert property (p_push) else $error("interrupt did not push");
  a_full: assert property (p_full) else $error("stack depth past four");
  a_pop: assert property (p_pop) else $error("return did not pop");
  a_sub: assert property (p_sub) else $error("high pc changed on subtract");
  a_user: assert property (p_user) else $error("user area flag wrong");
  a_bus: assert property (p_bus) else $error("wait state count wrong");
endmodule // pcv_core_sva

bind pcv_core pcv_core_sva #(.PC_W(PC_W)) i_pcv_core_sva (
  .ref_clk(ref_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .op_irq(op_irq), .op_return_from_interrupt(op_return_from_interrupt),
  .op_table_read(op_table_read), .op_add_pcl(op_add_pcl), .op_sub_pcl(op_sub_pcl),
  .fetch_addr(fetch_addr), .rom_rd(rom_rd), .busy(busy),
  .user_area_exceeded(user_area_exceeded), .stack_depth(stack_depth)
);

// >>> bench/pcv_core_tb.sv
// Purpose: Self-checking bench for pcv_core
// Assumes: ROM model answers while rom_rd is high
// Notes: Ops go one at a time, never while busy
`timescale 1ns/10ps
`include "pcv_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pcv_core_tb;
  // ==========================================================
  // Signals
  localparam [8:0] k_jump = 9'h002, k_irq = 9'h004, k_return_from_interrupt = 9'h008, k_save = 9'h010;
  localparam [8:0] k_rest = 9'h020, k_tbl = 9'h040, k_add = 9'h080, k_sub = 9'h100;
  logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest, rom_rd, busy;
  logic reset_by_watchdog, reset_by_external, user_area_exceeded;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [8:0] ops;
  logic [9:0] jump_target, fetch_addr;
  logic [15:0] rom_addr, rom_data;
  logic [2:0] stack_depth;
  int fail_count = 0, n_checks = 0, i;
  pcv_core i_pcv_core (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .op_step(ops[0]), .op_jump(ops[1]), .jump_target(jump_target), .op_irq(ops[2]),
    .op_return_from_interrupt(ops[3]), .op_save(ops[4]), .op_restore(ops[5]), .op_table_read(ops[6]),
    .op_add_pcl(ops[7]), .op_sub_pcl(ops[8]), .reset_by_watchdog(reset_by_watchdog),
    .reset_by_external(reset_by_external), .fetch_addr(fetch_addr), .rom_addr(rom_addr),
    .rom_rd(rom_rd), .rom_data(rom_data), .busy(busy),
    .user_area_exceeded(user_area_exceeded), .stack_depth(stack_depth));
  pcv_rom i_pcv_rom (.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Tasks
  task bus(input wr, input [4:0] a, input [7:0] v);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, v};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest) begin
      @(posedge ref_clk);
    end
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task op(input [8:0] m, input [9:0] t);
    @(posedge ref_clk);
    ops <= m;
    jump_target <= t;
    @(posedge ref_clk);
    ops <= 9'h000;
    #1;
  endtask
  task rst(input wd, input ex);
    @(posedge ref_clk);
    rstn <= 1'b0;
    reset_by_watchdog <= wd;
    reset_by_external <= ex;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset_by_watchdog <= 1'b0;
    reset_by_external <= 1'b0;
    #1;
  endtask
  task results;
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    rstn = 1'b0;
    {avs_read, avs_write, reset_by_watchdog, reset_by_external} = 4'h0;
    {avs_address, avs_writedata, ops, jump_target} = 56'h0;
    rst(1'b0, 1'b0);
    `CHK(fetch_addr, 10'h000)
    bus(0, `PCV_OFF_FLAG, 0); `CHK(d, 32'h80)
    bus(0, 5'h01, 0); `CHK(d, 32'h0)
    $display("test power_on done");
    bus(1, `PCV_OFF_ACC, 8'h3c); bus(1, `PCV_OFF_FLAG, 8'hc5); op(k_save, 0);
    bus(1, `PCV_OFF_ACC, 8'h00); bus(1, `PCV_OFF_FLAG, 8'h00); op(k_rest, 0);
    bus(0, `PCV_OFF_ACC, 0); `CHK(d, 32'h3c)
    bus(0, `PCV_OFF_FLAG, 0); `CHK(d, 32'h85)
    $display("test save_restore done");
    bus(1, `PCV_OFF_LIDX, 8'hff); bus(1, `PCV_OFF_MIDX, 8'h12); op(k_tbl, 0);
    `CHK(rom_addr, 16'h12ff)
    bus(0, `PCV_OFF_ACC, 0); `CHK(d, 32'ha5)
    bus(0, `PCV_OFF_LOOKUP, 0); `CHK(d, 32'h2e)
    bus(0, `PCV_OFF_MIDX, 0); `CHK(d, 32'h12)
    $display("test table_read done");
    op(k_jump, 10'h0f0); bus(1, `PCV_OFF_ACC, 8'h20);
    op(k_add, 0); `CHK(fetch_addr, 10'h110)
    op(k_sub, 0); `CHK(fetch_addr, 10'h1f0)
    bus(1, `PCV_OFF_PCL, 8'hff); op(9'h001, 0); `CHK(fetch_addr, 10'h200)
    $display("test pc_arith done");
    for (i = 0; i < 5; i++) begin
      op(k_jump, 10'(10'h100 + i));
      op(k_irq, 0); `CHK(fetch_addr, 10'h008)
    end
    `CHK(stack_depth, 3'h4)
    for (i = 4; i > 0; i--) begin
      op(k_return_from_interrupt, 0); `CHK(fetch_addr, 10'(10'h100 + i))
    end
    `CHK(stack_depth, 3'h0)
    $display("test stack done");
    op(k_jump, 10'h3fd);
    @(posedge ref_clk);
    #1 `CHK(user_area_exceeded, 1'b1)
    op(k_jump, 10'h3fc);
    @(posedge ref_clk);
    #1 `CHK(user_area_exceeded, 1'b0)
    $display("test user_area done");
    op(k_irq, 0); bus(1, `PCV_OFF_ACC, 8'h77);
    rst(1'b1, 1'b0); `CHK(fetch_addr, 10'h000)
    bus(0, `PCV_OFF_FLAG, 0); `CHK(d, 32'h00)
    bus(0, `PCV_OFF_ACC, 0); `CHK(d, 32'h00)
    bus(0, `PCV_OFF_STAT, 0); `CHK(d, 32'h00)
    rst(1'b0, 1'b1); bus(0, `PCV_OFF_FLAG, 0); `CHK(d, 32'hc0)
    $display("test reset_causes done");
    results;
  end
  initial begin
    #20000;
    fail_count++;
    results;
  end
endmodule // pcv_core_tb

// >>> bench/pcv_rom.sv
// Purpose: Program ROM model for the table-read port
// Assumes: A word is wanted only while rom_rd is high
// Notes: Off-read data are inverted so stale words never pass
`timescale 1ns/10ps
module pcv_rom (
  input wire [15:0] rom_addr,
  input wire rom_rd,
  output wire [15:0] rom_data
);
  // ==========================================================
  // Content
  // Word is its address mixed with a fixed pattern
  assign rom_data = rom_rd ? (rom_addr ^ 16'h3c5a) : ~(rom_addr ^ 16'h3c5a);
endmodule // pcv_rom

// >>> design/pcv_core.v
// Purpose: Program counter, vectoring, save buffer and ROM table reads
// Assumes: Op pulses come from the instruction decoder, one per cycle at most
// Notes: ROM data are taken at the edge that ends the cycle in which rom_rd is high
`timescale 1ns/10ps
`include "pcv_regs.vh"

module pcv_core #(
  parameter PC_W = 10
) (
  input wire ref_clk,
  input wire rstn,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire op_step,
  input wire op_jump,
  input wire [PC_W-1:0] jump_target,
  input wire op_irq,
  input wire op_return_from_interrupt,
  input wire op_save,
  input wire op_restore,
  input wire op_table_read,
  input wire op_add_pcl,
  input wire op_sub_pcl,
  input wire reset_by_watchdog,
  input wire reset_by_external,
  output wire [PC_W-1:0] fetch_addr,
  output reg [15:0] rom_addr,
  output reg rom_rd,
  input wire [15:0] rom_data,
  output wire busy,
  output reg user_area_exceeded,
  output wire [2:0] stack_depth
);
  localparam ST_IDLE = 2'b01;
  localparam ST_TBL = 2'b10;
  localparam HI_W = PC_W - 8;
  localparam [PC_W-1:0] RST_VEC = `PCV_RESET_VECTOR;
  localparam [PC_W-1:0] IRQ_VEC = `PCV_IRQ_VECTOR;

  reg [1:0] state;
  reg [7:0] accumulator;
  reg [7:0] flag_low;
  reg timeout_cause_flag;
  reg power_down_cause_flag;
  reg cause_taken;
  reg [7:0] low_index;
  reg [7:0] mid_index;
  reg [7:0] lookup_buffer;
  reg [7:0] pc_low_byte;
  reg [HI_W-1:0] pc_high_part;
  reg [7:0] save_acc;
  reg [7:0] save_flag;
  reg save_full;
  reg bus_ack;
  reg [7:0] next_rdata;
  reg [8:0] pcl_sum;
  reg [7:0] pcl_diff;
  wire [PC_W-1:0] pc;
  wire [PC_W-1:0] stack_top;
  wire [7:0] program_flag_register;
  wire bus_req;
  wire bus_wr;
  wire cmd_ok;
  wire do_push;
  wire do_pop;

  // ==========================================================
  // Program counter view and flag register
  assign pc = {pc_high_part, pc_low_byte};
  assign fetch_addr = pc;
  assign program_flag_register = {timeout_cause_flag, power_down_cause_flag,
    flag_low[5:0]};
  assign busy = (state != ST_IDLE);
  assign cmd_ok = (state == ST_IDLE);

  // ==========================================================
  // Avalon slave: one wait cycle, then answer
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign bus_wr = avs_write & bus_ack & avs_byteenable[0];

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  always @* begin
    next_rdata = 8'h00;
    case (avs_address)
      `PCV_OFF_ACC: next_rdata = accumulator;
      `PCV_OFF_FLAG: next_rdata = program_flag_register;
      `PCV_OFF_LIDX: next_rdata = low_index;
      `PCV_OFF_MIDX: next_rdata = mid_index;
      `PCV_OFF_LOOKUP: next_rdata = lookup_buffer;
      `PCV_OFF_PCL: next_rdata = pc_low_byte;
      `PCV_OFF_PCH: next_rdata = {{(8-HI_W){1'b0}}, pc_high_part};
      `PCV_OFF_STAT: next_rdata = {3'h0, save_full, user_area_exceeded,
        stack_depth};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data registered while waitrequest is high, valid at the ack edge
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= {24'h000000, next_rdata};
    end
  end

  // ==========================================================
  // Return-address stack
  assign do_push = op_irq & cmd_ok;
  assign do_pop = op_return_from_interrupt & cmd_ok & ~op_irq;

  pcv_stack #(
    .W(PC_W),
    .DEPTH(`PCV_STACK_DEPTH)
  ) u_stack (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .push(do_push),
    .pop(do_pop),
    .push_data(pc),
    .top_data(stack_top),
    .depth(stack_depth)
  );

  // ==========================================================
  // Computed jump arithmetic
  always @* begin
    pcl_sum = {1'b0, pc_low_byte} + {1'b0, accumulator};
    pcl_diff = pc_low_byte - accumulator;
  end

  // ==========================================================
  // Program counter; interrupt wins over every other op
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_low_byte <= RST_VEC[7:0];
      pc_high_part <= RST_VEC[PC_W-1:8];
    end else if (cmd_ok) begin
      if (op_irq) begin
        pc_low_byte <= IRQ_VEC[7:0];
        pc_high_part <= IRQ_VEC[PC_W-1:8];
      end else if (op_return_from_interrupt) begin
        pc_low_byte <= stack_top[7:0];
        pc_high_part <= stack_top[PC_W-1:8];
      end else if (op_add_pcl) begin
        pc_low_byte <= pcl_sum[7:0];
        if (pcl_sum[8]) begin
          pc_high_part <= pc_high_part + {{(HI_W-1){1'b0}}, 1'b1};
        end
      end else if (op_sub_pcl) begin
        pc_low_byte <= pcl_diff;
      end else if (op_jump) begin
        pc_low_byte <= jump_target[7:0];
        pc_high_part <= jump_target[PC_W-1:8];
      end else if (op_step) begin
        {pc_high_part, pc_low_byte} <= pc + {{(PC_W-1){1'b0}}, 1'b1};
      end else if (bus_wr && avs_address == `PCV_OFF_PCL) begin
        pc_low_byte <= avs_writedata[7:0];
      end else if (bus_wr && avs_address == `PCV_OFF_PCH) begin
        pc_high_part <= avs_writedata[HI_W-1:0];
      end
    end
  end

  // Reserved words at the top must never hold user code
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      user_area_exceeded <= 1'b0;
    end else begin
      user_area_exceeded <= (pc > `PCV_USER_END);
    end
  end

  // ==========================================================
  // Reset cause, caught on the first edge after release
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cause_taken <= 1'b0;
      timeout_cause_flag <= `PCV_RST_TO;
      power_down_cause_flag <= `PCV_RST_PD;
    end else if (!cause_taken) begin
      cause_taken <= 1'b1;
      if (reset_by_watchdog) begin
        timeout_cause_flag <= 1'b0;
        power_down_cause_flag <= 1'b0;
      end else if (reset_by_external) begin
        timeout_cause_flag <= 1'b1;
        power_down_cause_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Table read sequencer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      rom_addr <= 16'h0000;
      rom_rd <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (op_table_read && !op_irq && !op_return_from_interrupt) begin
            rom_addr <= {mid_index, low_index};
            rom_rd <= 1'b1;
            state <= ST_TBL;
          end
        end
        ST_TBL: begin
          rom_rd <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          rom_rd <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Accumulator, flags and one-level save buffer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      accumulator <= `PCV_RST_BYTE;
      flag_low <= `PCV_RST_BYTE;
      lookup_buffer <= `PCV_RST_BYTE;
      save_acc <= `PCV_RST_BYTE;
      save_flag <= `PCV_RST_BYTE;
      save_full <= 1'b0;
    end else begin
      if (state == ST_TBL) begin
        accumulator <= rom_data[7:0];
        lookup_buffer <= rom_data[15:8];
      end else if (cmd_ok && op_restore && !op_irq && !op_return_from_interrupt) begin
        accumulator <= save_acc;
        flag_low <= save_flag & `PCV_FLAG_SAVE_MASK;
      end else begin
        if (bus_wr && avs_address == `PCV_OFF_ACC) begin
          accumulator <= avs_writedata[7:0];
        end
        if (bus_wr && avs_address == `PCV_OFF_FLAG) begin
          flag_low <= avs_writedata[7:0] & `PCV_FLAG_SAVE_MASK;
        end
        if (bus_wr && avs_address == `PCV_OFF_LOOKUP) begin
          lookup_buffer <= avs_writedata[7:0];
        end
      end
      // Single level: a second save overwrites the first
      if (cmd_ok && op_save && !op_irq && !op_return_from_interrupt) begin
        save_acc <= accumulator;
        save_flag <= flag_low & `PCV_FLAG_SAVE_MASK;
        save_full <= 1'b1;
      end else if (cmd_ok && op_restore && !op_irq && !op_return_from_interrupt) begin
        save_full <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Index registers; no hardware carry between them
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_index <= `PCV_RST_BYTE;
      mid_index <= `PCV_RST_BYTE;
    end else begin
      if (bus_wr && avs_address == `PCV_OFF_LIDX) begin
        low_index <= avs_writedata[7:0];
      end
      if (bus_wr && avs_address == `PCV_OFF_MIDX) begin
        mid_index <= avs_writedata[7:0];
      end
    end
  end
endmodule // pcv_core

// >>> design/pcv_stack.v
// Purpose: Return-address stack, shift organised
// Assumes: Push and pop never asserted together
// Notes: Push when full drops the deepest entry; pop when empty is ignored
`timescale 1ns/10ps
`include "pcv_regs.vh"

module pcv_stack #(
  parameter W = 10,
  parameter DEPTH = `PCV_STACK_DEPTH
) (
  input wire ref_clk,
  input wire rstn,
  input wire push,
  input wire pop,
  input wire [W-1:0] push_data,
  output wire [W-1:0] top_data,
  output reg [2:0] depth
);
  reg [DEPTH*W-1:0] mem;

  // ==========================================================
  // Entries; the top comes straight from a register
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      wire [W-1:0] shift_in_push;
      wire [W-1:0] shift_in_pop;
      // End entries get their neighbour by generate, so no index falls outside mem
      if (i == 0) begin : g_first
        assign shift_in_push = push_data;
      end else begin : g_rest
        assign shift_in_push = mem[(i-1)*W +: W];
      end
      if (i == DEPTH-1) begin : g_last
        assign shift_in_pop = {W{1'b0}};
      end else begin : g_inner
        assign shift_in_pop = mem[(i+1)*W +: W];
      end
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          mem[i*W +: W] <= {W{1'b0}};
        end else if (push) begin
          mem[i*W +: W] <= shift_in_push;
        end else if (pop && depth != 3'h0) begin
          mem[i*W +: W] <= shift_in_pop;
        end
      end
    end
  endgenerate

  assign top_data = mem[W-1:0];

  // ==========================================================
  // Fill level, saturating at four levels
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      depth <= 3'h0;
    end else if (push && depth != DEPTH[2:0]) begin
      depth <= depth + 3'h1;
    end else if (pop && depth != 3'h0) begin
      depth <= depth - 3'h1;
    end
  end
endmodule // pcv_stack

// >>> pkg/pcv_regs.vh
// Purpose: Constants for the program counter and vectoring block
// Assumes: Byte addresses on the register bus, one 32-bit word per register
// Notes: Registers hold 8 bits in lane 0, upper bits read as zero
//
// How it works
// - Every reset leaves the fetch address at word zero.
// - Power-on gives timeout 1 and power-down 0, watchdog gives 0 and 0, external gives 1 and 1.
// - Every reset returns all registers except the two cause flags to defaults and restarts at address zero.
// - Both reset-cause flags read back as bits of the program flag register.
// - An interrupt pushes the current program counter and then loads the interrupt vector.
// - All interrupt sources share the one interrupt vector address.
// - Save copies accumulator and flags except the cause flags; restore leaves those two alone.
// - User code ends at 03fc; the last three words are reserved and flagged if reached.
// - Table reads address ROM with the middle index as bits 15..8 and the low index as 7..0.
// - A table read puts the word's low byte in the accumulator and high byte in the lookup buffer.
// - The low index wrapping from ff to 00 never touches the middle index.
// - Adding the accumulator to the low pc byte carries into the high pc part.
// - Subtracting from the low pc byte never changes the high pc part.
// - The return-address stack holds exactly four levels.
`ifndef PCV_REGS_VH
`define PCV_REGS_VH

// ==========================================================
// Register byte offsets
`define PCV_OFF_ACC 5'h00
`define PCV_OFF_FLAG 5'h04
`define PCV_OFF_LIDX 5'h08
`define PCV_OFF_MIDX 5'h0c
`define PCV_OFF_LOOKUP 5'h10
`define PCV_OFF_PCL 5'h14
`define PCV_OFF_PCH 5'h18
`define PCV_OFF_STAT 5'h1c

// ==========================================================
// Flag register layout
`define PCV_FLAG_TO_BIT 7
`define PCV_FLAG_PD_BIT 6
`define PCV_FLAG_SAVE_MASK 8'h07

// ==========================================================
// Vectors and memory map
`define PCV_RESET_VECTOR 10'h000
`define PCV_IRQ_VECTOR 10'h008
`define PCV_USER_END 10'h3fc

// ==========================================================
// Reset values and stack size
`define PCV_RST_BYTE 8'h00
`define PCV_RST_TO 1'b1
`define PCV_RST_PD 1'b0
`define PCV_STACK_DEPTH 4

`endif
